/* File: rtl/pinstrap_cfg.svh */
`ifndef PINSTRAP_CFG_SVH
`define PINSTRAP_CFG_SVH

// register byte addresses
`define OFF_STATUS      8'h00
`define OFF_STRAP_A     8'h04
`define OFF_STRAP_B     8'h08
`define OFF_BOOT_PHASE  8'h0c
`define OFF_VID_TARGET  8'h10
`define OFF_EVENTS      8'h14

// event register field positions
`define EVT_FAULT_BIT   0
`define EVT_THERM_BIT   1
`define EVT_BOOT_BIT    2
`define EVT_WIDTH       3

// reset values
`define VID_TARGET_RST  8'h00
`define EVENTS_RST      3'h0

// strap sample slots
`define SLOT_ADDR_SLEW  0
`define SLOT_FREQ_MAX_CURRENT_CODE  1
`define SLOT_OCL_RAMP   2
`define SLOT_OS_US      3
`define SLOT_BOOT       4
`define SLOT_SLEW_MODE  5
`define SLOT_CFG_SRC    6
`define STRAP_SLOTS     7

// timing
`define CLK_MHZ             250
`define ENABLE_DEBOUNCE_NS  100
`define ENABLE_DEBOUNCE_CYC ((`ENABLE_DEBOUNCE_NS * `CLK_MHZ + 999) / 1000)
`define RESET_HOLD_NS       1000
`define RESET_HOLD_CYC      ((`RESET_HOLD_NS * `CLK_MHZ + 999) / 1000)

`endif

/* File: rtl/pinstrap_pkg.sv */
package pinstrap_pkg;

  // one quantized strap reading: resistor code and divider ratio (v/vref * 1024)
  typedef struct packed {
    logic [2:0] resCode;
    logic [9:0] voltCode;
  } strap_sample_t;

  typedef struct packed {
    logic [1:0] riseSlew;
    logic [3:0] mgmtAddr;
    logic [2:0] freqSel;
    logic [7:0] maxCurrentCode;
    logic [3:0] overcurrentLimit;
    logic [1:0] rampLevel;
    logic [2:0] overshootReduction;
    logic [2:0] undershootReduction;
    logic [7:0] bootVid;
    logic [2:0] outputSlew;
    logic       legacyVidTable;
    logic       pairedInterleave;
    logic       dynPhaseEnable;
    logic       zeroLoadLine;
    logic       configFromNvm;
    logic [4:0] phaseDisable;
  } strap_settings_t;

  typedef enum logic [1:0] {
    WAIT_SUPPLY = 2'b00,
    WAIT_CONV   = 2'b01,
    HELD        = 2'b11
  } latch_state_t;

endpackage

/* File: rtl/pinstrap_config_latch.sv */
`timescale 1ns/1ns
`default_nettype none
`include "pinstrap_cfg.svh"

// Operation
// - address/slew resistor bits 2:1 pick rise slew
// - address/slew resistor bit 0 is boot LSB
// - address/slew voltage gives 4-bit bus address
// - straps latched at supply up, then frozen
// - enable accepted after 100 ns stable
// - frequency resistor; voltage gives 255*V/Vref code
// - current-limit strap picks one of sixteen
// - current-limit voltage picks one of four ramps
// - overshoot/undershoot levels, seven each or off
// - alert is open-drain pull-low interrupt line
// - reset low over 1000 ns restores boot
// - config-source resistor picks straps or memory
// - slew/mode resistor picks one of eight slews
// - mode bit 7 selects voltage table generation
// - mode bit 6 selects paired interleaving
// - mode bit 4 enables dynamic phase shedding
// - mode bit 3 selects zero load-line
// - boot strap supplies boot bits 7:1
// - listed faults pull fault indicator low
// - thermal flag open-drain, active low
module pinstrap_config_latch (
  input  wire logic                                          core_clk,
  input  wire logic                                          rst,
  input  wire logic                                          s_axi_awvalid,
  output logic                                               s_axi_awready,
  input  wire logic [7:0]                                    s_axi_awaddr,
  input  wire logic                                          s_axi_wvalid,
  output logic                                               s_axi_wready,
  input  wire logic [31:0]                                   s_axi_wdata,
  input  wire logic [3:0]                                    s_axi_wstrb,
  output logic                                               s_axi_bvalid,
  input  wire logic                                          s_axi_bready,
  output logic [1:0]                                         s_axi_bresp,
  input  wire logic                                          s_axi_arvalid,
  output logic                                               s_axi_arready,
  input  wire logic [7:0]                                    s_axi_araddr,
  output logic                                               s_axi_rvalid,
  input  wire logic                                          s_axi_rready,
  output logic [31:0]                                        s_axi_rdata,
  output logic [1:0]                                         s_axi_rresp,
  input  wire pinstrap_pkg::strap_sample_t [`STRAP_SLOTS-1:0] strapSamples,
  input  wire logic                                          convDone,
  input  wire logic                                          supplyUp,
  input  wire logic [4:0]                                    phaseSenseTied,
  input  wire logic                                          enableIn,
  input  wire logic                                          resetPinN,
  input  wire logic                                          hsShort,
  input  wire logic                                          overTemp,
  input  wire logic                                          outOvervoltage,
  input  wire logic                                          inOvercurrent,
  input  wire logic                                          thermalHot,
  output pinstrap_pkg::strap_settings_t                      settings,
  output logic                                               settingsValid,
  output logic                                               enableOut,
  output logic [7:0]                                         vidTarget,
  output logic                                               bootReturn,
  output logic                                               regulatorFaultNOut,
  output logic                                               regulatorFaultNOe,
  output logic                                               thermalFlagNOut,
  output logic                                               thermalFlagNOe,
  output logic                                               mgmtAlertNOut,
  output logic                                               mgmtAlertNOe
);
  import pinstrap_pkg::*;

  localparam logic [5:0] DEB_CYC  = 6'(`ENABLE_DEBOUNCE_CYC);
  localparam logic [8:0] HOLD_CYC = 9'(`RESET_HOLD_CYC);

  latch_state_t          state_reg;
  strap_settings_t       decoded;
  logic [17:0]           imaxProduct;
  logic [44:0]           settingsHi_reg;
  logic [4:0]            phaseDisable_reg;
  logic [5:0]            debCount_reg;
  logic [8:0]            holdCount_reg;
  logic                  faultEvent;
  logic                  faultLatched_reg;
  logic                  thermal_reg;
  logic [`EVT_WIDTH-1:0] events_reg;
  logic [`EVT_WIDTH-1:0] events_next;
  logic [`EVT_WIDTH-1:0] eventSet;
  logic                  awHeld_reg;
  logic                  wHeld_reg;
  logic [7:0]            awAddr_reg;
  logic [31:0]           wData_reg;
  logic [3:0]            wStrb_reg;
  logic                  writeFire;
  logic                  vidWrite;
  logic                  evtWrite;
  logic                  wrMapped;
  logic [31:0]           readWord;
  logic                  rdMapped;

  // converter output is already quantized; this maps codes to fields and rescales the max-current voltage to 8 bits
  always_comb begin
    imaxProduct = 18'(strapSamples[`SLOT_FREQ_MAX_CURRENT_CODE].voltCode) * 18'd255 + 18'd512;
    decoded = '0;
    decoded.riseSlew            = strapSamples[`SLOT_ADDR_SLEW].resCode[2:1];
    decoded.mgmtAddr            = strapSamples[`SLOT_ADDR_SLEW].voltCode[9:6];
    decoded.freqSel             = strapSamples[`SLOT_FREQ_MAX_CURRENT_CODE].resCode;
    decoded.maxCurrentCode      = imaxProduct[17:10];
    decoded.overcurrentLimit    = {strapSamples[`SLOT_OCL_RAMP].resCode,
                                   strapSamples[`SLOT_OCL_RAMP].voltCode[9]};
    decoded.rampLevel           = strapSamples[`SLOT_OCL_RAMP].voltCode[9:8];
    decoded.overshootReduction  = strapSamples[`SLOT_OS_US].resCode;
    decoded.undershootReduction = strapSamples[`SLOT_OS_US].voltCode[9:7];
    decoded.bootVid             = {strapSamples[`SLOT_BOOT].voltCode[9:6],
                                   strapSamples[`SLOT_BOOT].resCode,
                                   strapSamples[`SLOT_ADDR_SLEW].resCode[0]};
    decoded.outputSlew          = strapSamples[`SLOT_SLEW_MODE].resCode;
    decoded.legacyVidTable      = strapSamples[`SLOT_SLEW_MODE].voltCode[9];
    decoded.pairedInterleave    = strapSamples[`SLOT_SLEW_MODE].voltCode[8];
    decoded.dynPhaseEnable      = strapSamples[`SLOT_SLEW_MODE].voltCode[7];
    decoded.zeroLoadLine        = strapSamples[`SLOT_SLEW_MODE].voltCode[6];
    decoded.configFromNvm       = strapSamples[`SLOT_CFG_SRC].resCode[2];
    decoded.phaseDisable        = '0;
  end

  // capture sequencer: wait for supply, wait for a fresh conversion, hold
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= WAIT_SUPPLY;
    end else begin
      case (state_reg)
        WAIT_SUPPLY: if (supplyUp) state_reg <= WAIT_CONV;
        WAIT_CONV: begin
          if (!supplyUp) state_reg <= WAIT_SUPPLY;
          else if (convDone) state_reg <= HELD;
        end
        HELD: if (!supplyUp) state_reg <= WAIT_SUPPLY;
        default: state_reg <= WAIT_SUPPLY;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      settingsValid <= 1'b0;
    end else begin
      settingsValid <= (state_reg == HELD) && supplyUp;
    end
  end

  // fields other than phase disables load once per supply-up
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      settingsHi_reg <= '0;
    end else if (state_reg == WAIT_CONV && supplyUp && convDone) begin
      settingsHi_reg <= decoded[49:5];
    end
  end

  // one driver per register; the port is only their concatenation
  assign settings = {settingsHi_reg, phaseDisable_reg};

  // a sense input strapped to the 3.3 V rail marks the phase unused
  genvar ph;
  generate
    for (ph = 0; ph < 5; ph++) begin : g_phase
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          phaseDisable_reg[ph] <= 1'b0;
        end else if (state_reg == WAIT_CONV && supplyUp && convDone) begin
          phaseDisable_reg[ph] <= phaseSenseTied[ph];
        end
      end
    end
  endgenerate

  // enable debounce: the new level must hold for the full window
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      enableOut    <= 1'b0;
      debCount_reg <= '0;
    end else if (enableIn == enableOut) begin
      debCount_reg <= '0;
    end else if (debCount_reg == DEB_CYC - 6'd1) begin
      enableOut    <= enableIn;
      debCount_reg <= '0;
    end else begin
      debCount_reg <= debCount_reg + 6'd1;
    end
  end

  // reset pin: one pulse once low time passes the threshold
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      holdCount_reg <= '0;
      bootReturn    <= 1'b0;
    end else begin
      bootReturn <= 1'b0;
      if (resetPinN) begin
        holdCount_reg <= '0;
      end else if (holdCount_reg != HOLD_CYC) begin
        holdCount_reg <= holdCount_reg + 9'd1;
        bootReturn    <= (holdCount_reg == HOLD_CYC - 9'd1);
      end
    end
  end

  // boot return wins over a software write in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      vidTarget <= `VID_TARGET_RST;
    end else if (bootReturn) begin
      vidTarget <= settings.bootVid;
    end else if (vidWrite && wStrb_reg[0]) begin
      vidTarget <= wData_reg[7:0];
    end
  end

  assign faultEvent = hsShort | overTemp | outOvervoltage | inOvercurrent;

  // fault stays latched: the system is expected to cut input power
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      faultLatched_reg <= 1'b0;
      thermal_reg      <= 1'b0;
    end else begin
      if (faultEvent) faultLatched_reg <= 1'b1;
      thermal_reg <= thermalHot;
    end
  end

  assign eventSet = {bootReturn, thermalHot & ~thermal_reg, faultEvent & ~faultLatched_reg};

  always_comb begin
    events_next = events_reg;
    if (evtWrite && wStrb_reg[0]) events_next = events_next & ~wData_reg[`EVT_WIDTH-1:0];
    events_next = events_next | eventSet;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      events_reg <= `EVENTS_RST;
    end else begin
      events_reg <= events_next;
    end
  end

  // open-drain pins: data is always low, only the enable moves
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      regulatorFaultNOut <= 1'b0;
      thermalFlagNOut    <= 1'b0;
      mgmtAlertNOut      <= 1'b0;
      regulatorFaultNOe  <= 1'b0;
      thermalFlagNOe     <= 1'b0;
      mgmtAlertNOe       <= 1'b0;
    end else begin
      regulatorFaultNOut <= 1'b0;
      thermalFlagNOut    <= 1'b0;
      mgmtAlertNOut      <= 1'b0;
      regulatorFaultNOe  <= faultLatched_reg | faultEvent;
      thermalFlagNOe     <= thermalHot;
      mgmtAlertNOe       <= |events_next;
    end
  end

  // bus write side: address and data may come in either order
  assign writeFire = awHeld_reg && wHeld_reg && !s_axi_bvalid;
  assign vidWrite  = writeFire && (awAddr_reg == `OFF_VID_TARGET);
  assign evtWrite  = writeFire && (awAddr_reg == `OFF_EVENTS);
  assign wrMapped  = (awAddr_reg == `OFF_VID_TARGET) || (awAddr_reg == `OFF_EVENTS);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      awHeld_reg    <= 1'b0;
      awAddr_reg    <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      awHeld_reg    <= 1'b1;
      awAddr_reg    <= {s_axi_awaddr[7:2], 2'b00};
    end else if (writeFire) begin
      awHeld_reg <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_wready <= 1'b1;
      wHeld_reg    <= 1'b0;
      wData_reg    <= '0;
      wStrb_reg    <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      wHeld_reg    <= 1'b1;
      wData_reg    <= s_axi_wdata;
      wStrb_reg    <= s_axi_wstrb;
    end else if (writeFire) begin
      wHeld_reg <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (writeFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrMapped ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // bus read side
  always_comb begin
    readWord = '0;
    rdMapped = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `OFF_STATUS:     readWord = {24'h0, thermal_reg, faultLatched_reg, settings.configFromNvm,
                                   enableOut, 2'b00, state_reg};
      `OFF_STRAP_A:    readWord = {12'h0, settings.zeroLoadLine, settings.dynPhaseEnable,
                                   settings.pairedInterleave, settings.legacyVidTable,
                                   1'b0, settings.outputSlew, 1'b0, settings.freqSel,
                                   settings.mgmtAddr, 2'b00, settings.riseSlew};
      `OFF_STRAP_B:    readWord = {10'h0, settings.undershootReduction, 1'b0,
                                   settings.overshootReduction, settings.rampLevel,
                                   settings.overcurrentLimit, 1'b0, settings.maxCurrentCode};
      `OFF_BOOT_PHASE: readWord = {19'h0, settings.phaseDisable, settings.bootVid};
      `OFF_VID_TARGET: readWord = {24'h0, vidTarget};
      `OFF_EVENTS:     readWord = {29'h0, events_reg};
      default:         rdMapped = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= readWord;
      s_axi_rresp   <= rdMapped ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // pinstrap_config_latch

`default_nettype wire

/* File: verif/pinstrap_props.sv */
`timescale 1ns/1ns
`default_nettype none
module pinstrap_props
  import pinstrap_pkg::*;
(
  input wire logic                          core_clk,
  input wire logic                          rst,
  input wire logic                          supplyUp,
  input wire logic                          enableIn,
  input wire logic                          resetPinN,
  input wire logic                          hsShort,
  input wire logic                          overTemp,
  input wire logic                          outOvervoltage,
  input wire logic                          inOvercurrent,
  input wire logic                          thermalHot,
  input wire pinstrap_pkg::strap_settings_t settings,
  input wire logic                          settingsValid,
  input wire logic                          enableOut,
  input wire logic [7:0]                    vidTarget,
  input wire logic                          bootReturn,
  input wire logic                          regulatorFaultNOut,
  input wire logic                          regulatorFaultNOe,
  input wire logic                          thermalFlagNOut,
  input wire logic                          thermalFlagNOe,
  input wire logic                          mgmtAlertNOut,
  input wire logic                          mgmtAlertNOe
);
  import pinstrap_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic       prevIn;
  logic [5:0] stableCnt;
  logic [8:0] lowCnt;
  // counters saturate so long idle stretches cannot wrap into false matches
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prevIn    <= 1'b0;
      stableCnt <= 6'h00;
    end else begin
      prevIn    <= enableIn;
      stableCnt <= (enableIn != prevIn) ? 6'h00 : ((stableCnt == 6'h3f) ? stableCnt : stableCnt + 6'h01);
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) lowCnt <= 9'h000;
    else lowCnt <= resetPinN ? 9'h000 : ((lowCnt == 9'h1ff) ? lowCnt : lowCnt + 9'h001);
  end
  a_enable_settle: assert property (enableOut != $past(enableOut) |-> enableOut == enableIn && stableCnt >= 24)
    else $error("enable output moved before input settled");
  a_enable_late: assert property (stableCnt == 25 |-> enableOut == enableIn)
    else $error("enable output missed a settled input");
  a_boot_count: assert property (bootReturn |-> lowCnt == 9'd250)
    else $error("boot return at wrong reset low time");
  a_boot_target: assert property (bootReturn |=> vidTarget == settings.bootVid && !bootReturn)
    else $error("target not restored to boot code");
  a_fault_set: assert property (hsShort || overTemp || outOvervoltage || inOvercurrent |=> regulatorFaultNOe)
    else $error("fault indicator not pulled low");
  a_fault_hold: assert property (regulatorFaultNOe |=> regulatorFaultNOe)
    else $error("fault indicator released");
  a_thermal_follow: assert property (1'b1 |=> thermalFlagNOe == $past(thermalHot))
    else $error("thermal flag does not follow condition");
  a_od_low: assert property (!regulatorFaultNOut && !thermalFlagNOut && !mgmtAlertNOut)
    else $error("open drain pin driven high");
  a_settings_frozen: assert property (settingsValid && $past(settingsValid) |-> $stable(settings))
    else $error("held settings changed");
  a_valid_drop: assert property ($fell(supplyUp) |=> !settingsValid)
    else $error("settings still valid after supply loss");
  a_alert_fault: assert property ($rose(regulatorFaultNOe) |-> ##[0:2] mgmtAlertNOe)
    else $error("no alert on fault");
endmodule  // pinstrap_props
bind pinstrap_config_latch pinstrap_props u_props (.core_clk, .rst, .supplyUp, .enableIn, .resetPinN, .hsShort,
  .overTemp, .outOvervoltage, .inOvercurrent, .thermalHot, .settings, .settingsValid, .enableOut, .vidTarget,
  .bootReturn, .regulatorFaultNOut, .regulatorFaultNOe, .thermalFlagNOut, .thermalFlagNOe, .mgmtAlertNOut,
  .mgmtAlertNOe);
`default_nettype wire

/* File: verif/strap_model.sv */
`timescale 1ns/1ns
`default_nettype none
`include "pinstrap_cfg.svh"
module strap_model
  import pinstrap_pkg::*;
(
  input  wire logic                                       core_clk,
  input  wire logic                                       rst,
  input  wire logic                                       supplyUp,
  input  wire logic                                       alt,
  output pinstrap_pkg::strap_sample_t [`STRAP_SLOTS-1:0] strapSamples,
  output logic                                            convDone,
  output logic [4:0]                                      phaseSenseTied
);
  import pinstrap_pkg::*;
  strap_sample_t reading;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) convDone <= 1'b0;
    else convDone <= supplyUp;
  end
  assign reading = alt ? {3'h6, 10'h058} : {3'h3, 10'h3a7};
  // unsettled converter shows the inverse, so an early capture is visible
  assign strapSamples = {`STRAP_SLOTS{convDone ? reading : ~reading}};
  assign phaseSenseTied = alt ? 5'h15 : 5'h0a;
endmodule  // strap_model
`default_nettype wire

/* File: verif/tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "pinstrap_cfg.svh"
module tb;
  import pinstrap_pkg::*;
  logic        core_clk = 1'b0, rst = 1'b1, supplyUp = 1'b0, strapAlt = 1'b0, enableIn = 1'b0, resetPinN = 1'b1;
  logic        thermalHot = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0]  faultIn = 4'h0, s_axi_wstrb = 4'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, vidTarget;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, convDone;
  logic        settingsValid, enableOut, bootReturn, regulatorFaultNOut, regulatorFaultNOe;
  logic        thermalFlagNOut, thermalFlagNOe, mgmtAlertNOut, mgmtAlertNOe;
  logic [4:0]  phaseSenseTied;
  strap_sample_t [`STRAP_SLOTS-1:0] strapSamples;
  strap_settings_t settings;
  int          num_errors = 0, n_compared = 0;
  always #2 core_clk = ~core_clk;
  strap_model u_straps (.core_clk, .rst, .supplyUp, .alt(strapAlt), .strapSamples, .convDone, .phaseSenseTied);
  pinstrap_config_latch dut (.core_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .strapSamples,
    .convDone, .supplyUp, .phaseSenseTied, .enableIn, .resetPinN, .hsShort(faultIn[0]), .overTemp(faultIn[1]),
    .outOvervoltage(faultIn[2]), .inOvercurrent(faultIn[3]), .thermalHot, .settings, .settingsValid, .enableOut,
    .vidTarget, .bootReturn, .regulatorFaultNOut, .regulatorFaultNOe, .thermalFlagNOut, .thermalFlagNOe,
    .mgmtAlertNOut, .mgmtAlertNOe);
  task automatic print_verdict;
    $display("errors %0d, comparisons %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // ready and valid are registered, so values read right after the edge are the sampled ones
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic check_straps(input logic alt);
    check(settings.riseSlew, alt ? 32'h3 : 32'h1);
    check(settings.bootVid[0], alt ? 32'h0 : 32'h1);
    check(settings.mgmtAddr, alt ? 32'h1 : 32'he);
    check(settings.freqSel, alt ? 32'h6 : 32'h3);
    check(settings.maxCurrentCode, alt ? 32'h16 : 32'he9);
    check(settings.overcurrentLimit, alt ? 32'hc : 32'h7);
    check(settings.rampLevel, alt ? 32'h0 : 32'h3);
    check({settings.overshootReduction, settings.undershootReduction}, alt ? 32'h30 : 32'h1f);
    check(settings.configFromNvm, alt ? 32'h1 : 32'h0);
    check(settings.outputSlew, alt ? 32'h6 : 32'h3);
    check(settings.legacyVidTable, alt ? 32'h0 : 32'h1);
    check(settings.pairedInterleave, alt ? 32'h0 : 32'h1);
    check(settings.dynPhaseEnable, alt ? 32'h0 : 32'h1);
    check(settings.zeroLoadLine, alt ? 32'h1 : 32'h0);
    check(settings.bootVid, alt ? 32'h1c : 32'he7);
    check(settings.phaseDisable, alt ? 32'h15 : 32'h0a);
  endtask
  task automatic power_up(input logic alt);
    int t;
    @(posedge core_clk);
    strapAlt <= alt;
    supplyUp <= 1'b1;
    for (t = 0; t < 20 && settingsValid !== 1'b1; t++) @(posedge core_clk);
    check(settingsValid, 1'b1);
    check_straps(alt);
  endtask
  task automatic test_straps;
    power_up(1'b0);
    strapAlt <= 1'b1;
    repeat (5) @(posedge core_clk);
    check_straps(1'b0);
    supplyUp <= 1'b0;
    repeat (3) @(posedge core_clk);
    check(settingsValid, 1'b0);
    power_up(1'b1);
  endtask
  task automatic test_enable;
    enableIn <= 1'b1;
    repeat (24) @(posedge core_clk);
    enableIn <= 1'b0;
    repeat (30) @(posedge core_clk);
    check(enableOut, 1'b0);
    enableIn <= 1'b1;
    repeat (20) @(posedge core_clk);
    check(enableOut, 1'b0);
    repeat (10) @(posedge core_clk);
    check(enableOut, 1'b1);
    axi_read(`OFF_STATUS, rd, rsp);
    check(rd[7:0], 8'h33);
  endtask
  task automatic test_boot;
    axi_write(`OFF_VID_TARGET, 32'h5a, rsp);
    axi_read(`OFF_VID_TARGET, rd, rsp);
    check(rd[7:0], 8'h5a);
    resetPinN <= 1'b0;
    repeat (240) @(posedge core_clk);
    resetPinN <= 1'b1;
    repeat (3) @(posedge core_clk);
    check(vidTarget, 8'h5a);
    resetPinN <= 1'b0;
    repeat (260) @(posedge core_clk);
    check(vidTarget, 8'h1c);
    check(mgmtAlertNOe, 1'b1);
    resetPinN <= 1'b1;
    axi_write(`OFF_EVENTS, 32'h7, rsp);
    repeat (3) @(posedge core_clk);
    check(mgmtAlertNOe, 1'b0);
    axi_read(8'h40, rd, rsp);
    check(rsp, 2'b10);
    check(rd, 32'h0);
    axi_read(`OFF_STRAP_B, rd, rsp);
    check(rd, 32'h00031816);
    axi_write(8'h40, 32'h1, rsp);
    check(rsp, 2'b10);
  endtask
  task automatic test_faults;
    int i;
    for (i = 0; i < 4; i++) begin
      rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      repeat (3) @(posedge core_clk);
      check(regulatorFaultNOe, 1'b0);
      faultIn <= 4'h1 << i;
      @(posedge core_clk);
      faultIn <= 4'h0;
      repeat (4) @(posedge core_clk);
      check({regulatorFaultNOe, regulatorFaultNOut}, 2'b10);
    end
    thermalHot <= 1'b1;
    repeat (3) @(posedge core_clk);
    check({thermalFlagNOe, thermalFlagNOut}, 2'b10);
    thermalHot <= 1'b0;
    repeat (3) @(posedge core_clk);
    check(thermalFlagNOe, 1'b0);
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    test_straps();
    test_enable();
    test_boot();
    test_faults();
    print_verdict();
  end
endmodule  // tb
`default_nettype wire
